/* File: rtl/brake_ctrl.sv */
`timescale 1ns/1ps
module brake_ctrl
  import brake_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Drive signals
  input  wire logic        servo_enable_input,
  input  wire logic [15:0] filtered_motor_speed,
  input  wire logic [15:0] bus_voltage,
  input  wire logic [15:0] cmd_in,
  input  wire logic        cmd_in_valid,
  output logic             holding_brake_output,
  output logic             motor_power_on,
  output logic             phase_short_relay,
  output logic [15:0]      cmd_out,
  output logic             cmd_out_valid
);

  brake_cfg_t  cfg;            // Software settings
  logic [15:0] bus_rated_reg;  // Rated bus voltage, ADC units
  brake_stat_t stat;           // Sequencer state
  logic        relay_close;    // Relay decision
  logic        en_meta_reg;    // Enable synchroniser stage 1
  logic        en_sync_reg;    // Enable synchroniser stage 2
  logic        wr_pend_reg;    // Write data phase pending
  logic        rd_pend_reg;    // Read data phase pending
  logic [7:0]  addr_reg;       // Latched address
  logic        addr_phase;     // Valid transfer address phase

  // Enable arrives from a pin: two flops before use
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_meta_reg <= 1'b0;
      en_sync_reg <= 1'b0;
    end
    else if (ce)
    begin
      en_meta_reg <= servo_enable_input;
      en_sync_reg <= en_meta_reg;
    end
  end

  // Brake sequencer
  brake_sequencer u_seq (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .enable  (en_sync_reg),
    .speed   (filtered_motor_speed),
    .cfg     (cfg),
    .stat    (stat)
  );

  // Dynamic brake relay
  dyn_brake_relay u_relay (
    .hclk        (hclk),
    .hresetn     (hresetn),
    .ce          (ce),
    .bus_voltage (bus_voltage),
    .bus_rated   (bus_rated_reg),
    .relay_close (relay_close)
  );

  // Registered pin outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      holding_brake_output <= 1'b0;
      motor_power_on       <= 1'b0;
      phase_short_relay    <= 1'b0;
    end
    else if (ce)
    begin
      holding_brake_output <= stat.brake_release;
      motor_power_on       <= stat.motor_power;
      phase_short_relay    <= relay_close;
    end
  end

  // Command gate: blocked until accept delay has run out
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cmd_out       <= 16'h0000;
      cmd_out_valid <= 1'b0;
    end
    else if (ce)
    begin
      cmd_out_valid <= cmd_in_valid && stat.cmd_accept;
      if (cmd_in_valid && stat.cmd_accept)
        cmd_out <= cmd_in;
    end
  end

  // AHB address phase qualifier
  assign addr_phase = hsel && hready && htrans[1];

  // Latch address phase; every access is zero wait state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else if (ce)
    begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase)
        addr_reg <= haddr;
    end
  end

  // Register writes in the data phase; only low 16 bits are kept
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg.accept_delay <= RST_ACCEPT_DELAY;
      cfg.zero_speed   <= RST_ZERO_SPEED;
      cfg.hold_time    <= RST_HOLD_TIME;
      cfg.max_wait     <= RST_MAX_WAIT;
      cfg.brake_assign <= RST_BRAKE_ASSIGN;
      bus_rated_reg    <= RST_BUS_RATED;
    end
    else if (ce && wr_pend_reg)
    begin
      case (addr_reg)
        ADDR_ACCEPT_DELAY: cfg.accept_delay <= hwdata[15:0];
        ADDR_ZERO_SPEED:   cfg.zero_speed   <= hwdata[15:0];
        ADDR_HOLD_TIME:    cfg.hold_time    <= hwdata[15:0];
        ADDR_MAX_WAIT:     cfg.max_wait     <= hwdata[15:0];
        ADDR_BUS_RATED:    bus_rated_reg    <= hwdata[15:0];
        ADDR_CONTROL:      cfg.brake_assign <= hwdata[CTRL_BRAKE_ASSIGN];
        default:           ;  // Unmapped or read-only: ignored
      endcase
    end
  end

  // Read data registered at the address phase so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ce && addr_phase && !hwrite)
    begin
      case (haddr)
        ADDR_ACCEPT_DELAY: hrdata <= {16'h0000, cfg.accept_delay};
        ADDR_ZERO_SPEED:   hrdata <= {16'h0000, cfg.zero_speed};
        ADDR_HOLD_TIME:    hrdata <= {16'h0000, cfg.hold_time};
        ADDR_MAX_WAIT:     hrdata <= {16'h0000, cfg.max_wait};
        ADDR_BUS_RATED:    hrdata <= {16'h0000, bus_rated_reg};
        ADDR_CONTROL:      hrdata <= {31'h00000000, cfg.brake_assign};
        ADDR_STATUS:       hrdata <= {19'h00000, stat.state, 3'h0,
                                      en_sync_reg, relay_close,
                                      stat.cmd_accept, stat.motor_power,
                                      stat.brake_release};
        default:           hrdata <= 32'h00000000;
      endcase
    end
  end

  // Always ready, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

endmodule : brake_ctrl

/* File: rtl/brake_pkg.sv */
package brake_pkg;

  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0]  ADDR_ACCEPT_DELAY = 8'h00;
  localparam logic [7:0]  ADDR_ZERO_SPEED   = 8'h04;
  localparam logic [7:0]  ADDR_HOLD_TIME    = 8'h08;
  localparam logic [7:0]  ADDR_MAX_WAIT     = 8'h0C;
  localparam logic [7:0]  ADDR_BUS_RATED    = 8'h10;
  localparam logic [7:0]  ADDR_CONTROL      = 8'h14;
  localparam logic [7:0]  ADDR_STATUS       = 8'h18;

  // Reset values
  localparam logic [15:0] RST_ACCEPT_DELAY  = 16'h00FA;
  localparam logic [15:0] RST_ZERO_SPEED    = 16'h001E;
  localparam logic [15:0] RST_HOLD_TIME     = 16'h0096;
  localparam logic [15:0] RST_MAX_WAIT      = 16'h01F4;
  localparam logic [15:0] RST_BUS_RATED     = 16'h0136;
  localparam logic [0:0]  RST_BRAKE_ASSIGN  = 1'h1;

  // Control register field positions
  localparam int          CTRL_BRAKE_ASSIGN = 0;

  // Status register field positions
  localparam int          STAT_RELEASE      = 0;
  localparam int          STAT_POWER        = 1;
  localparam int          STAT_ACCEPT       = 2;
  localparam int          STAT_RELAY        = 3;
  localparam int          STAT_ENABLE       = 4;
  localparam int          STAT_STATE        = 8;

  // Static brake speed limit in rpm
  localparam logic [15:0] STATIC_SPEED_RPM  = 16'h0014;

  // Dynamic brake thresholds as percent of rated bus voltage
  localparam logic [6:0]  RELAY_OPEN_PCT    = 7'h46;
  localparam logic [6:0]  RELAY_CLOSE_PCT   = 7'h41;

  // Millisecond tick: 1 ms at 25 MHz
  localparam int          CLK_HZ            = 25000000;
  localparam int          TICK_MS           = 1;
  localparam int          CYCLES_PER_MS     = CLK_HZ / 1000 * TICK_MS;

  // Brake sequencer states
  typedef enum logic [4:0] {
    ST_LOCKED  = 5'b00001,
    ST_RELEASE = 5'b00010,
    ST_RUN     = 5'b00100,
    ST_WAIT    = 5'b01000,
    ST_HOLD    = 5'b10000
  } brake_state_t;

  // Settings passed from the register file to the sequencer
  typedef struct packed {
    logic [15:0] accept_delay;
    logic [15:0] zero_speed;
    logic [15:0] hold_time;
    logic [15:0] max_wait;
    logic        brake_assign;
  } brake_cfg_t;

  // Sequencer outputs
  typedef struct packed {
    logic        brake_release;
    logic        motor_power;
    logic        cmd_accept;
    logic [4:0]  state;
  } brake_stat_t;

endpackage : brake_pkg

/* File: rtl/dyn_brake_relay.sv */
`timescale 1ns/1ps
module dyn_brake_relay
  import brake_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic [15:0] bus_voltage,
  input  wire logic [15:0] bus_rated,
  output logic             relay_close
);

  logic [22:0] volt_scaled;   // Voltage times 100
  logic [22:0] open_level;    // Rated times 70
  logic [22:0] close_level;   // Rated times 65

  // Compare in scaled units so no divider is needed
  always_comb
  begin
    volt_scaled = 23'(bus_voltage) * 23'h64;
    open_level  = 23'(bus_rated) * 23'(RELAY_OPEN_PCT);
    close_level = 23'(bus_rated) * 23'(RELAY_CLOSE_PCT);
  end

  // Hysteresis relay, evaluated every enabled cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      relay_close <= 1'b0;
    else if (ce)
    begin
      if (volt_scaled > open_level)
        relay_close <= 1'b0;              // Phases open
      else if (volt_scaled < close_level)
        relay_close <= 1'b1;              // Short U and V
      // Otherwise keep the last state
    end
  end

endmodule : dyn_brake_relay

/* File: rtl/brake_sequencer.sv */
`timescale 1ns/1ps
module brake_sequencer
  import brake_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        enable,
  input  wire logic [15:0] speed,
  input  wire brake_cfg_t  cfg,
  output brake_stat_t      stat
);

  brake_state_t state_reg;     // Sequencer state
  logic [14:0]  div_reg;       // Cycle divider for ms tick
  logic         tick;          // One ms has elapsed
  logic [15:0]  ms_reg;        // Milliseconds in current state
  logic         enable_d_reg;  // Last enable, for edge detect
  logic         fall;          // Enable ON to OFF
  logic         rise;          // Enable OFF to ON

  assign tick = (div_reg == 15'(CYCLES_PER_MS - 1));
  assign fall = enable_d_reg && !enable;
  assign rise = !enable_d_reg && enable;

  // Free-running ms divider
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      div_reg <= 15'h0000;
    else if (ce)
      div_reg <= tick ? 15'h0000 : div_reg + 15'h0001;
  end

  // Enable history
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      enable_d_reg <= 1'b0;
    else if (ce)
      enable_d_reg <= enable;
  end

  // State and ms timer; timer restarts on each state change
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg <= ST_LOCKED;
      ms_reg    <= 16'h0000;
    end
    else if (ce)
    begin
      case (state_reg)
        ST_LOCKED:
        begin
          // Enable powers motor and releases brake together
          if (rise)
          begin
            state_reg <= ST_RELEASE;
            ms_reg    <= 16'h0000;
          end
        end
        ST_RELEASE:
        begin
          if (fall)
          begin
            state_reg <= ST_HOLD;       // Too early to move; lock now
            ms_reg    <= 16'h0000;
          end
          else if (ms_reg >= cfg.accept_delay)
          begin
            state_reg <= ST_RUN;        // Commands now valid
            ms_reg    <= 16'h0000;
          end
          else if (tick)
            ms_reg <= ms_reg + 16'h0001;
        end
        ST_RUN:
        begin
          if (fall)
          begin
            ms_reg <= 16'h0000;         // Start brake wait timer
            if (speed < STATIC_SPEED_RPM)
              state_reg <= ST_HOLD;     // Static lock at once
            else
              state_reg <= ST_WAIT;     // Dynamic sequence
          end
        end
        ST_WAIT:
        begin
          if (speed < cfg.zero_speed || ms_reg > cfg.max_wait)
          begin
            state_reg <= ST_HOLD;       // Zero speed or timeout
            ms_reg    <= 16'h0000;
          end
          else if (tick)
            ms_reg <= ms_reg + 16'h0001;
        end
        ST_HOLD:
        begin
          // Power held only when brake output is assigned
          if (!cfg.brake_assign || ms_reg >= cfg.hold_time)
          begin
            state_reg <= ST_LOCKED;
            ms_reg    <= 16'h0000;
          end
          else if (tick)
            ms_reg <= ms_reg + 16'h0001;
        end
        default:
        begin
          state_reg <= ST_LOCKED;
          ms_reg    <= 16'h0000;
        end
      endcase
    end
  end

  // Decode outputs from state
  always_comb
  begin
    stat.brake_release = (state_reg == ST_RELEASE) || (state_reg == ST_RUN)
                         || (state_reg == ST_WAIT);
    stat.motor_power   = (state_reg != ST_LOCKED);
    stat.cmd_accept    = (state_reg == ST_RUN);
    stat.state         = state_reg;
  end

endmodule : brake_sequencer

/* File: bench/brake_ctrl_chk.sv */
`timescale 1ns/1ps
module brake_ctrl_chk
  import brake_pkg::*;
#(
  parameter int HOLD_MAX = 25010 // One ms tick plus a little slack
)
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        servo_enable_input,
  input wire logic [15:0] filtered_motor_speed,
  input wire logic [15:0] bus_voltage,
  input wire logic [15:0] cmd_in,
  input wire logic        cmd_in_valid,
  input wire logic        holding_brake_output,
  input wire logic        motor_power_on,
  input wire logic        phase_short_relay,
  input wire logic [15:0] cmd_out,
  input wire logic        cmd_out_valid
);
  logic        hi;       // Bus above the open threshold
  logic        lo;       // Bus below the close threshold
  logic [15:0] hold_cnt; // Cycles spent locked yet powered

  // Thresholds assume the rated voltage keeps its reset value
  assign hi = int'(bus_voltage) * 32'h64 > int'(RST_BUS_RATED) * int'(RELAY_OPEN_PCT);
  assign lo = int'(bus_voltage) * 32'h64 < int'(RST_BUS_RATED) * int'(RELAY_CLOSE_PCT);

  // Length of the powered span after a lock
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hold_cnt <= 16'h0000;
    else if (motor_power_on && !holding_brake_output)
      hold_cnt <= hold_cnt + 16'h0001;
    else
      hold_cnt <= 16'h0000;
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Enable dropped while running slowly, speed kept low
  sequence s_slow_stop;
    holding_brake_output && $fell(servo_enable_input) && filtered_motor_speed <
      STATIC_SPEED_RPM ##1 (filtered_motor_speed < STATIC_SPEED_RPM) [*3];
  endsequence

  a_relay_opens: assert property (hi [*3] |-> !phase_short_relay)
    else $error("relay closed above upper threshold");
  a_relay_closes: assert property (lo [*3] |-> phase_short_relay)
    else $error("relay open below lower threshold");
  a_relay_keeps: assert property ((!hi && !lo) [*4] |-> $stable(phase_short_relay))
    else $error("relay moved inside the band");
  a_cmd_pass: assert property (cmd_out_valid |-> $past(cmd_in_valid) && cmd_out == $past(cmd_in))
    else $error("command out without matching input");
  a_cmd_locked: assert property (!motor_power_on [*3] |-> !cmd_out_valid)
    else $error("command passed while unpowered");
  a_static_lock: assert property (s_slow_stop |-> ##[0:2] !holding_brake_output)
    else $error("brake not locked after slow stop");
  a_hold_span: assert property (hold_cnt < 16'(HOLD_MAX))
    else $error("power kept on too long after lock");
  a_reset_idle: assert property (disable iff (1'b0) !hresetn |-> hreadyout && !hresp &&
      !holding_brake_output && !motor_power_on && !phase_short_relay && !cmd_out_valid)
    else $error("outputs not idle in reset");
endmodule : brake_ctrl_chk

bind brake_ctrl brake_ctrl_chk u_chk
(
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .servo_enable_input(servo_enable_input), .filtered_motor_speed(filtered_motor_speed),
  .bus_voltage(bus_voltage), .cmd_in(cmd_in), .cmd_in_valid(cmd_in_valid),
  .holding_brake_output(holding_brake_output), .motor_power_on(motor_power_on),
  .phase_short_relay(phase_short_relay), .cmd_out(cmd_out), .cmd_out_valid(cmd_out_valid)
);

/* File: bench/brake_host.sv */
`timescale 1ns/1ps
module brake_host
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        want_en,            // Bench asks for enable
  input  wire logic        go,                 // Quiet period known to be over
  input  wire logic        rude,               // Command during quiet period on purpose
  output logic             servo_enable_input,
  output logic [15:0]      cmd_in,
  output logic             cmd_in_valid
);
  logic [1:0] phase; // Spaces commands four cycles apart

  // Enable pin and motion commands, changed just after each edge
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      servo_enable_input <= 1'b0;
      phase              <= 2'h0;
      cmd_in_valid       <= 1'b0;
      cmd_in             <= 16'h0000;
    end
    else
    begin
      servo_enable_input <= want_en;
      phase              <= phase + 2'h1;
      // Silent through the quiet period unless told to misbehave
      cmd_in_valid       <= want_en && (go || rude) && phase == 2'h0;
      // Changes every cycle so a stale value is never mistaken for fresh
      cmd_in             <= cmd_in + 16'h03C5;
    end
  end
endmodule : brake_host

/* File: bench/brake_ctrl_bench.sv */
`timescale 1ns/1ps
module brake_ctrl_bench
  import brake_pkg::*;
;
  logic        hclk = 1'b0;      // Bus clock
  logic        hresetn = 1'b1;   // Reset, pulled low at time zero so a real edge resets
  logic [7:0]  haddr = 8'h00;    // Bus address
  logic [1:0]  htrans = 2'h0;    // Transfer kind
  logic        hwrite = 1'b0;    // Write flag
  logic [31:0] hwdata = 32'h0;   // Write data
  logic [15:0] speed = 16'h0000; // Motor speed in rpm
  logic [15:0] volts = 16'h00D2; // Bus voltage, mid band
  logic        want_en = 1'b0;   // Host enable request
  logic        go = 1'b0;        // Host may command
  logic        rude = 1'b0;      // Host ignores the quiet period
  logic [31:0] rd;               // Last read word
  logic [31:0] prev_cmd = 32'h0; // Command seen one edge earlier
  int          failures = 0;     // Mismatches
  int          n_tests = 0;      // Comparisons
  int          n_out = 0;        // Commands passed by the block
  wire logic [31:0] hrdata;
  wire logic        hreadyout, hresp, servo_enable_input, cmd_in_valid;
  wire logic        brake, power, relay, cmd_out_valid;
  wire logic [15:0] cmd_in, cmd_out;

  brake_ctrl uut
  (
    .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .servo_enable_input(servo_enable_input),
    .filtered_motor_speed(speed), .bus_voltage(volts), .cmd_in(cmd_in),
    .cmd_in_valid(cmd_in_valid), .holding_brake_output(brake), .motor_power_on(power),
    .phase_short_relay(relay), .cmd_out(cmd_out), .cmd_out_valid(cmd_out_valid)
  );

  brake_host host
  (
    .hclk(hclk), .hresetn(hresetn), .want_en(want_en), .go(go), .rude(rude),
    .servo_enable_input(servo_enable_input), .cmd_in(cmd_in), .cmd_in_valid(cmd_in_valid)
  );

  // 25 MHz
  always #20 hclk = ~hclk;

  // Every passed command must be the one offered an edge earlier
  always @(posedge hclk)
  begin
    if (cmd_out_valid === 1'b1)
    begin
      n_out++;
      chk("cmd_out", prev_cmd, {16'h0000, cmd_out});
    end
    prev_cmd = {16'h0000, cmd_in};
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // One single AHB-Lite transfer; waits on hready with no assumed latency
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] q);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results

  // Watchdog: three ms waits of at most 1, 1 and 2 ms plus bus traffic fit in 5 ms
  initial
  begin
    #5_000_000;
    failures++;
    results();
  end

  initial
  begin
    logic [31:0] rv [6];
    logic [15:0] bnd [6];
    int          v;
    int          t;
    logic        exp_relay;
    rv  = '{32'(RST_ACCEPT_DELAY), 32'(RST_ZERO_SPEED), 32'(RST_HOLD_TIME),
            32'(RST_MAX_WAIT), 32'(RST_BUS_RATED), 32'(RST_BRAKE_ASSIGN)};
    bnd = '{16'h00D9, 16'h00DA, 16'h00CA, 16'h00C9, 16'h00D2, 16'h00E6};
    hresetn <= 1'b0;
    void'($urandom(58));
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values, random readback, unmapped place
    for (int i = 0; i < 6; i++)
    begin
      ahb(1'b0, 8'(4 * i), 32'h0, rd);
      chk("reset value", rv[i], rd);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = int'($urandom);
      ahb(1'b1, 8'(4 * i), 32'(v), rd);
      ahb(1'b0, 8'(4 * i), 32'h0, rd);
      chk("readback", {16'h0000, 16'(v)}, rd);
    end
    ahb(1'b1, 8'h1C, 32'hFFFFFFFF, rd);
    ahb(1'b0, 8'h1C, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    ahb(1'b1, ADDR_ACCEPT_DELAY, 32'h1, rd);
    ahb(1'b1, ADDR_ZERO_SPEED, 32'h1E, rd);
    ahb(1'b1, ADDR_HOLD_TIME, 32'h1, rd);
    ahb(1'b1, ADDR_MAX_WAIT, 32'h1, rd);
    // Relay against an integer model: band edges first, then random levels
    exp_relay = 1'b0;
    for (int i = 0; i < 40; i++)
    begin
      v = (i < 6) ? int'(bnd[i]) : 32'hB4 + int'($urandom % 32'h3C);
      volts <= 16'(v);
      repeat (4) @(posedge hclk);
      if (v * 32'h64 > int'(RST_BUS_RATED) * int'(RELAY_OPEN_PCT))
        exp_relay = 1'b0;
      else if (v * 32'h64 < int'(RST_BUS_RATED) * int'(RELAY_CLOSE_PCT))
        exp_relay = 1'b1;
      chk("relay", {31'h0, exp_relay}, {31'h0, relay});
    end
    // Enable, commands offered too early, then slow stop
    speed   <= 16'h000A;
    rude    <= 1'b1;
    want_en <= 1'b1;
    // Poll status; every command offered before the accept bit must be dropped
    do
    begin
      t = n_out;
      ahb(1'b0, ADDR_STATUS, 32'h0, rd);
    end
    while (rd[STAT_ACCEPT] !== 1'b1);
    chk("early commands", 32'h0, 32'(t));
    rude <= 1'b0;
    chk("status", 32'h7, {29'h0, rd[2:0]});
    go <= 1'b1;
    repeat (200) @(posedge hclk);
    chk("late commands", 32'h1, 32'(n_out > 0));
    go      <= 1'b0;
    want_en <= 1'b0;
    // Lock must follow the sync delay only; power still on when it does
    t = 0;
    while (brake !== 1'b0)
    begin
      @(posedge hclk);
      t++;
    end
    chk("slow stop", 32'h6, {29'h0, 1'(t < 8), power, brake});
    t = 0;
    while (power !== 1'b0)
    begin
      @(posedge hclk);
      t++;
    end
    chk("hold span", 32'h1, 32'(t > 2 && t < 25010));
    // Fast stop, then speed falls under the zero-speed threshold
    ahb(1'b1, ADDR_HOLD_TIME, 32'h0, rd);
    ahb(1'b1, ADDR_ACCEPT_DELAY, 32'h0, rd);
    speed   <= 16'h0064;
    want_en <= 1'b1;
    while (brake !== 1'b1) @(posedge hclk);
    repeat (20) @(posedge hclk);
    want_en <= 1'b0;
    repeat (50) @(posedge hclk);
    chk("fast stop", 32'h1, {31'h0, brake});
    speed <= 16'h0019;
    repeat (8) @(posedge hclk);
    chk("zero speed lock", 32'h0, {31'h0, brake});
    // Fast stop that never slows: timeout lock
    while (power !== 1'b0) @(posedge hclk);
    speed   <= 16'h0064;
    want_en <= 1'b1;
    while (brake !== 1'b1) @(posedge hclk);
    repeat (20) @(posedge hclk);
    want_en <= 1'b0;
    t = 0;
    while (brake !== 1'b0)
    begin
      @(posedge hclk);
      t++;
    end
    chk("wait span", 32'h1, 32'(t > 25000 && t < 50010));
    // Brake output not assigned: power drops with the lock, hold time ignored
    while (power !== 1'b0) @(posedge hclk);
    ahb(1'b1, ADDR_HOLD_TIME, 32'h2, rd);
    ahb(1'b1, ADDR_CONTROL, 32'h0, rd);
    speed   <= 16'h000A;
    want_en <= 1'b1;
    while (brake !== 1'b1) @(posedge hclk);
    repeat (20) @(posedge hclk);
    want_en <= 1'b0;
    while (brake !== 1'b0) @(posedge hclk);
    t = 0;
    while (power !== 1'b0)
    begin
      @(posedge hclk);
      t++;
    end
    chk("unassigned hold", 32'h1, 32'(t < 4));
    results();
  end
endmodule : brake_ctrl_bench
